// [design/slm_top.sv]
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "slm_params.svh"

module slm_top
  import slm_pkg::*;
#(
  parameter int MS_CYCLES = `SLM_CLK_HZ / `SLM_MS_PER_S
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        select_req,
  input  wire logic        select_via_fieldbus,
  input  wire logic [1:0]  level_req,
  input  wire logic [15:0] elec_speed,
  input  wire logic [15:0] slip_speed,
  input  wire logic [15:0] setpoint_in,
  output logic [15:0]      setpoint_out,
  output logic             quick_stop_req,
  output logic [15:0]      quick_stop_ramp_time,
  output logic [15:0]      ramp_pos_speed_limit,
  output logic [15:0]      ramp_neg_speed_limit,
  output logic             limited_speed_active_flag,
  output logic             stop_a_req,
  output logic             stop_b_req,
  output logic             irq
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Magnitude of a signed speed; the most negative value still fits unsigned.
  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'((~v) + 16'h0001) : v;
  endfunction : mag
  // Merge write data into a register under the byte strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  localparam logic [16:0] ACC_MAX = 17'(`SLM_ACCEPT_MAX_S * `SLM_MS_PER_S);
  localparam logic [15:0] RTIME_MS = 16'(`SLM_RAMP_TIME_S * `SLM_MS_PER_S);
  slm_level_type  level_q [4];
  slm_state_type  st_q;
  slm_limits_type lim_q;
  logic           en_q;
  logic [1:0]     mode_q;
  logic           slip_q;
  logic [7:0]     pct_q;
  logic [15:0]    seldly_q;
  logic [15:0]    rref_q;
  logic [15:0]    rdly_q;
  logic [15:0]    rtime_q;
  logic [16:0]    accept_q;
  logic [15:0]    qstop_q;
  logic [2:0]     irq_sts_q;
  logic [2:0]     irq_en_q;
  logic [16:0]    acc_left_q;
  logic           acc_on_q;
  logic [15:0]    pre_q;
  logic [15:0]    tmr_q;
  logic [15:0]    ramp_lim_q;
  logic [31:0]    racc_q;
  logic [15:0]    load_q;
  logic [31:0]    rdata_q;
  // --------------------------------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------------------------------
  logic       wr_go;
  logic       rd_go;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [1:0] wsel;
  logic       acc_go;
  logic [2:0] irq_clr;
  logic [1:0] lvl;
  // Address and data are taken together, one write outstanding at a time.
  assign s_axi_awready = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = ce & ~s_axi_rvalid;
  assign wr_go         = s_axi_awready;
  assign rd_go         = s_axi_arready & s_axi_arvalid;
  assign wa            = {s_axi_awaddr[7:2], 2'b00};
  assign ra            = {s_axi_araddr[7:2], 2'b00};
  assign wsel          = 2'(wa[4:2] - 3'h1);
  assign acc_go  = wr_go & (wa == `SLM_A_CTRL) & s_axi_wstrb[0] & s_axi_wdata[`SLM_F_ACC_GO];
  assign irq_clr = (wr_go & (wa == `SLM_A_IRQ_CLR) & s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'h0;
  // Write response: decode errors for addresses past the end of the map.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wa > `SLM_A_IRQ_EN) ? 2'h3 : 2'h0;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Software-written settings.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_q     <= 1'b1;
      mode_q   <= `SLM_MODE_RAMP;                          // [RULE_02]
      slip_q   <= 1'b0;
      pct_q    <= `SLM_R_PCT;
      seldly_q <= `SLM_SEL_DELAY_MS;
      rref_q   <= `SLM_R_RREF;
      rdly_q   <= `SLM_RAMP_DELAY_MS;
      rtime_q  <= RTIME_MS;
      accept_q <= `SLM_ACCEPT_MS;
      qstop_q  <= `SLM_QSTOP_MS;
      irq_en_q <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        level_q[i] <= '{stop_b: 1'b0, rpm: `SLM_R_LEVEL_RPM}; // [RULE_03] [RULE_08]
      end
    end else if (ce && wr_go) begin
      case (wa)
        `SLM_A_CTRL: begin
          if (s_axi_wstrb[0]) begin
            en_q   <= s_axi_wdata[`SLM_F_EN];
            mode_q <= s_axi_wdata[`SLM_F_MODE +: 2];
            slip_q <= s_axi_wdata[`SLM_F_SLIP];
          end
        end
        `SLM_A_LEVEL0, 8'h08, 8'h0c, 8'h10: begin
          level_q[wsel] <= 17'(merge({15'h0, level_q[wsel]}, s_axi_wdata, s_axi_wstrb));
        end
        `SLM_A_PCT:    pct_q    <= 8'(merge({24'h0, pct_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_SELDLY: seldly_q <= 16'(merge({16'h0, seldly_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_RREF:   rref_q   <= 16'(merge({16'h0, rref_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_RDLY:   rdly_q   <= 16'(merge({16'h0, rdly_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_RTIME:  rtime_q  <= 16'(merge({16'h0, rtime_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_QSTOP:  qstop_q  <= 16'(merge({16'h0, qstop_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_IRQ_EN: irq_en_q <= 3'(merge({29'h0, irq_en_q}, s_axi_wdata, s_axi_wstrb));
        `SLM_A_ACCEPT: begin
          // Longer times are cut to the ceiling so the test window stays bounded.
          if (merge({15'h0, accept_q}, s_axi_wdata, s_axi_wstrb) > {15'h0, ACC_MAX}) begin
            accept_q <= ACC_MAX;                              // [RULE_17]
          end else begin
            accept_q <= 17'(merge({15'h0, accept_q}, s_axi_wdata, s_axi_wstrb));
          end
        end
        default: ;
      endcase
    end
  end
  // Read data mux.
  always_comb begin
    case (ra)
      `SLM_A_CTRL:    rdata_q = {27'h0, slip_q, mode_q, en_q};
      `SLM_A_LEVEL0:  rdata_q = {15'h0, level_q[0]};
      8'h08:          rdata_q = {15'h0, level_q[1]};
      8'h0c:          rdata_q = {15'h0, level_q[2]};
      8'h10:          rdata_q = {15'h0, level_q[3]};
      `SLM_A_PCT:     rdata_q = {24'h0, pct_q};
      `SLM_A_SELDLY:  rdata_q = {16'h0, seldly_q};
      `SLM_A_RREF:    rdata_q = {16'h0, rref_q};
      `SLM_A_RDLY:    rdata_q = {16'h0, rdly_q};
      `SLM_A_RTIME:   rdata_q = {16'h0, rtime_q};
      `SLM_A_ACCEPT:  rdata_q = {15'h0, accept_q};
      `SLM_A_QSTOP:   rdata_q = {16'h0, qstop_q};
      `SLM_A_STATUS:  rdata_q = {28'h0, stop_a_req | stop_b_req, acc_on_q, quick_stop_req,
                                 limited_speed_active_flag};  // [RULE_11]
      `SLM_A_DIAG0:   rdata_q = {16'h0, load_q};              // [RULE_13]
      8'h38:          rdata_q = {16'h0, ramp_lim_q};
      8'h3c:          rdata_q = {16'h0, (st_q == SLM_IDLE) ? 16'h0 : level_q[lvl].rpm};
      `SLM_A_LIM0:    rdata_q = {16'h0, lim_q.pos};            // [RULE_06]
      8'h44:          rdata_q = {16'h0, lim_q.neg};
      8'h48:          rdata_q = {16'h0, lim_q.abs_lim};
      `SLM_A_IRQ_STS: rdata_q = {29'h0, irq_sts_q};
      `SLM_A_IRQ_EN:  rdata_q = {29'h0, irq_en_q};
      default:        rdata_q = 32'h0;
    endcase
  end
  // Read answer one cycle after the address is taken.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'h0;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_q;
        s_axi_rresp  <= (ra > `SLM_A_IRQ_EN) ? 2'h3 : 2'h0;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Speed, selection and timing
  // --------------------------------------------------------------------------
  logic        ms_tick;
  logic        sel_ok;
  logic        over_lvl;
  logic        over_ramp;
  logic [23:0] prod;
  logic [15:0] pct_lim;
  // Only the fieldbus path can name levels above the first.
  assign lvl      = select_via_fieldbus ? level_req : 2'h0;          // [RULE_04]
  assign ms_tick  = (pre_q == 16'(MS_CYCLES - 1));
  assign sel_ok   = en_q & select_req;                              // [RULE_12]
  assign over_lvl  = load_q > level_q[lvl].rpm;                     // [RULE_19]
  assign over_ramp = load_q > ramp_lim_q;
  assign prod     = level_q[lvl].rpm * pct_q;
  assign pct_lim  = (prod / 24'h000064 > 24'h007fff) ? `SLM_FULL_SCALE : 16'(prod / 24'h000064);
  // Load-side speed magnitude, slip-corrected when the motor is asynchronous.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_q <= 16'h0;
    end else if (ce) begin
      load_q <= mag(slip_q ? 16'(elec_speed - slip_speed) : elec_speed); // [RULE_14]
    end
  end
  // Millisecond prescaler shared by every timer.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 16'h0;
    end else if (ce) begin
      pre_q <= ms_tick ? 16'h0 : 16'(pre_q + 16'h0001);
    end
  end

  // --------------------------------------------------------------------------
  // Monitor sequence
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q  <= SLM_IDLE;
      tmr_q <= 16'h0;
    end else if (ce) begin
      case (st_q)
        SLM_IDLE: begin
          tmr_q <= 16'h0;
          if (sel_ok) begin
            st_q <= SLM_BRAKE;
          end
        end
        SLM_BRAKE: begin
          if (ms_tick && tmr_q != 16'hffff) begin
            tmr_q <= 16'(tmr_q + 16'h0001);
          end
          if (!sel_ok) begin
            st_q <= SLM_IDLE;
          end else if (mode_q == `SLM_MODE_RAMP) begin
            if (over_ramp) begin
              st_q <= SLM_STOPPED;
            end else if (ramp_lim_q <= level_q[lvl].rpm) begin
              st_q <= SLM_MONITOR;
            end
          end else if (tmr_q >= seldly_q) begin
            st_q <= SLM_MONITOR;                            // [RULE_07]
          end
        end
        SLM_MONITOR: begin
          if (!sel_ok) begin
            st_q <= SLM_IDLE;
          end else if (over_lvl) begin
            st_q <= SLM_STOPPED;                            // [RULE_19]
          end
        end
        SLM_STOPPED: begin
          if (!sel_ok) begin
            st_q <= SLM_IDLE;
          end
        end
        default: st_q <= SLM_IDLE;
      endcase
    end
  end
  // Ramp limit falls by the reference speed per ramp time after its delay.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ramp_lim_q <= `SLM_FULL_SCALE;
      racc_q     <= 32'h0;
    end else if (ce) begin
      if (st_q != SLM_BRAKE) begin
        ramp_lim_q <= (st_q == SLM_IDLE) ? load_q : ramp_lim_q;
        racc_q     <= 32'h0;
      end else if (tmr_q >= rdly_q) begin                   // [RULE_10]
        if (rtime_q == 16'h0) begin
          ramp_lim_q <= 16'h0;
        end else if (ms_tick) begin
          racc_q <= 32'(racc_q + {16'h0, rref_q});          // [RULE_09]
        end else if (racc_q >= {16'h0, rtime_q} && ramp_lim_q != 16'h0) begin
          racc_q     <= 32'(racc_q - {16'h0, rtime_q});
          ramp_lim_q <= 16'(ramp_lim_q - 16'h0001);
        end
      end
    end
  end
  // Acceptance window: limiting is lifted until the time runs out.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_on_q   <= 1'b0;
      acc_left_q <= 17'h0;
    end else if (ce) begin
      if (acc_go) begin
        acc_on_q   <= 1'b1;
        acc_left_q <= accept_q;
      end else if (acc_on_q && ms_tick) begin
        acc_left_q <= 17'(acc_left_q - 17'h00001);
        if (acc_left_q <= 17'h00001) begin
          acc_on_q <= 1'b0;                                 // [RULE_16]
        end
      end
    end
  end
  // Setpoint limits toward the ramp generator; full scale when not limiting.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lim_q <= '{pos: `SLM_FULL_SCALE, neg: 16'(-`SLM_FULL_SCALE), abs_lim: `SLM_FULL_SCALE};
    end else if (ce) begin
      if (st_q == SLM_IDLE || acc_on_q) begin
        lim_q <= '{pos: `SLM_FULL_SCALE, neg: 16'(-`SLM_FULL_SCALE), abs_lim: `SLM_FULL_SCALE};
      end else begin
        lim_q <= '{pos: pct_lim, neg: 16'(-pct_lim), abs_lim: pct_lim}; // [RULE_05] [RULE_16]
      end
    end
  end
  // Outputs toward the drive.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_out              <= 16'h0;
      quick_stop_req            <= 1'b0;
      limited_speed_active_flag <= 1'b0;
      stop_a_req                <= 1'b0;
      stop_b_req                <= 1'b0;
    end else if (ce) begin
      if ($signed(setpoint_in) > $signed(lim_q.pos)) begin
        setpoint_out <= lim_q.pos;                          // [RULE_05]
      end else if ($signed(setpoint_in) < $signed(lim_q.neg)) begin
        setpoint_out <= lim_q.neg;
      end else begin
        setpoint_out <= setpoint_in;
      end
      quick_stop_req            <= (st_q == SLM_BRAKE);     // [RULE_01]
      limited_speed_active_flag <= (st_q == SLM_MONITOR);   // [RULE_11]
      stop_a_req <= (st_q == SLM_STOPPED) & ~level_q[lvl].stop_b; // [RULE_08]
      stop_b_req <= (st_q == SLM_STOPPED) & level_q[lvl].stop_b;
    end
  end

  assign quick_stop_ramp_time = qstop_q;                    // [RULE_01]
  assign ramp_pos_speed_limit = lim_q.pos;                  // [RULE_15]
  assign ramp_neg_speed_limit = lim_q.neg;                  // [RULE_15]

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  logic [2:0] ev;

  // Violation, acceptance expiry, delay-mode monitoring start; a set beats a clear.
  assign ev = {st_q == SLM_BRAKE && sel_ok && mode_q != `SLM_MODE_RAMP && tmr_q >= seldly_q,
               acc_on_q && ms_tick && acc_left_q <= 17'h00001 && !acc_go,
               st_q != SLM_STOPPED && st_q != SLM_IDLE && sel_ok &&
               (st_q == SLM_MONITOR ? over_lvl : (mode_q == `SLM_MODE_RAMP && over_ramp))};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_sts_q <= 3'h0;
    end else if (ce) begin
      irq_sts_q <= (irq_sts_q & ~irq_clr) | ev;
    end
  end

  assign irq = |(irq_sts_q & irq_en_q);

endmodule : slm_top

// [design/slm_params.svh]
`ifndef SLM_PARAMS_SVH
`define SLM_PARAMS_SVH
// What this block does
// RULE_01 - On selection the motor is braked with the quick-stop ramp time.
// RULE_02 - Mode code 1 monitors a braking ramp, code 3 uses a delay; reset value 1.
// RULE_03 - Four monitored load-speed levels, each 2000 rpm after reset.
// RULE_04 - Levels two to four are usable only when selected over the fieldbus.
// RULE_05 - While active, the setpoint is clamped to level times percentage, 80 % default.
// RULE_06 - Effective limits readable: positive, negative and absolute.
// RULE_07 - Delay mode starts monitoring 100 ms after selection; ramp mode ignores it.
// RULE_08 - Each level has its own stop response: 0 is category A, 1 is B.
// RULE_09 - Ramp gradient comes from reference speed 1500 rpm over 10 s.
// RULE_10 - Ramp monitoring waits a delay of 250 ms before ramping down.
// RULE_11 - A status bit is 1 while limited-speed monitoring is active.
// RULE_12 - An enable bit of 1 enables the function, 0 inhibits it.
// RULE_13 - Diagnostics give load speed, ramp limit and limited-speed limit.
// RULE_14 - Induction motors: load speed is electrical speed corrected by slip.
// RULE_15 - The limits drive the ramp generator's positive and negative limits.
// RULE_16 - Acceptance mode suspends speed limiting for its time, then restores it.
// RULE_17 - Acceptance time defaults to 40000 ms and never exceeds 100 s.
// RULE_18 - Commissioning sets the delay longer than the worst braking time.
// RULE_19 - Active monitoring compares absolute speed to the level and stops on excess.

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define SLM_CLK_HZ          40000000
`define SLM_MS_PER_S        1000
`define SLM_SEL_DELAY_MS    16'h0064
`define SLM_RAMP_DELAY_MS   16'h00fa
`define SLM_RAMP_TIME_S     16'h000a
`define SLM_ACCEPT_MS       17'h09c40
`define SLM_ACCEPT_MAX_S    17'h00064
`define SLM_QSTOP_MS        16'h03e8

// ----------------------------------------------------------------------------
// Register offsets and fields
// ----------------------------------------------------------------------------
`define SLM_A_CTRL          8'h00
`define SLM_A_LEVEL0        8'h04
`define SLM_A_PCT           8'h14
`define SLM_A_SELDLY        8'h18
`define SLM_A_RREF          8'h1c
`define SLM_A_RDLY          8'h20
`define SLM_A_RTIME         8'h24
`define SLM_A_ACCEPT        8'h28
`define SLM_A_QSTOP         8'h2c
`define SLM_A_STATUS        8'h30
`define SLM_A_DIAG0         8'h34
`define SLM_A_LIM0          8'h40
`define SLM_A_IRQ_STS       8'h4c
`define SLM_A_IRQ_CLR       8'h50
`define SLM_A_IRQ_EN        8'h54
`define SLM_F_EN            0
`define SLM_F_MODE          1
`define SLM_F_SLIP          3
`define SLM_F_ACC_GO        4
`define SLM_F_STOPB         16
`define SLM_MODE_RAMP       2'h1
`define SLM_MODE_DELAY      2'h3
`define SLM_R_LEVEL_RPM     16'h07d0
`define SLM_R_PCT           8'h50
`define SLM_R_RREF          16'h05dc
`define SLM_FULL_SCALE      16'h7fff
`endif

// [design/slm_pkg.sv]
package slm_pkg;

  // Monitor sequence after a selection.
  typedef enum logic [1:0] {
    SLM_IDLE,
    SLM_BRAKE,
    SLM_MONITOR,
    SLM_STOPPED
  } slm_state_type;

  // One speed level with its own stop response.
  typedef struct packed {
    logic        stop_b;
    logic [15:0] rpm;
  } slm_level_type;

  // Positive, negative and absolute setpoint limits.
  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] neg;
    logic [15:0] abs_lim;
  } slm_limits_type;

endpackage : slm_pkg

// [verification/slm_top_asserts.sv]
`timescale 1ns/1ps
// ----
// Port checks
// ----
module slm_top_asserts (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        select_req,
  input wire logic        quick_stop_req,
  input wire logic [15:0] ramp_pos_speed_limit,
  input wire logic [15:0] ramp_neg_speed_limit,
  input wire logic        limited_speed_active_flag,
  input wire logic        stop_a_req,
  input wire logic        stop_b_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // A taken request must be answered on the next cycle.
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  // Phase outputs are exclusive; a stop ends monitoring.
  chk_limit_mirror: assert property (ramp_neg_speed_limit == 16'h0000 - ramp_pos_speed_limit)
    else $error("limits not mirrored");
  chk_phase_excl: assert property (!(quick_stop_req && limited_speed_active_flag))
    else $error("brake and monitor together");
  chk_stop_excl: assert property (!(stop_a_req && stop_b_req))
    else $error("both stop kinds");
  chk_stop_no_flag: assert property (stop_a_req || stop_b_req |-> !limited_speed_active_flag)
    else $error("active during stop");
  chk_deselect_idle: assert property ($fell(select_req) |-> ##[1:3]
    !(quick_stop_req || limited_speed_active_flag || stop_a_req || stop_b_req))
    else $error("no idle after deselect");
endmodule : slm_top_asserts

bind slm_top slm_top_asserts slm_top_asserts_i (.mclk, .rst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .select_req, .quick_stop_req, .ramp_pos_speed_limit, .ramp_neg_speed_limit,
  .limited_speed_active_flag, .stop_a_req, .stop_b_req);

// [verification/slm_drive_model.sv]
`timescale 1ns/1ps
// ----
// Drive model
// ----
module slm_drive_model (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [15:0] setpoint_out,
  output logic      [15:0] elec_speed
);
  logic signed [15:0] err_s;
  assign err_s = $signed(setpoint_out) - $signed(elec_speed);
  // Speed slews 8 rpm a cycle, fast enough to brake before monitoring starts.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      elec_speed <= 16'h0000;
    end else if (err_s > 16'sh0008) begin
      elec_speed <= elec_speed + 16'h0008;
    end else if (err_s < -16'sh0008) begin
      elec_speed <= elec_speed - 16'h0008;
    end else begin
      elec_speed <= setpoint_out;
    end
  end
endmodule : slm_drive_model

// [verification/slm_top_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin $display("unexpected %s expected %h seen %h", nm, e, g); err_count++; end end
module slm_top_bench;
  logic        mclk, rst_n, sel, fbus, force_on, qs, act, sa, sb, irq;
  logic        awv, awr, wv, bv, bry, arv, arr, rv, rry;
  logic [1:0]  lvl, rr, rrsp, br;
  logic [3:0]  ws;
  logic [7:0]  awa, ara;
  logic [15:0] slip, sp_in, sp_out, ev, mdl_ev, frc_ev, qst, lpos, lneg;
  logic [31:0] wd, rd_d, rdat;
  int          err_count, n_tests, nw;
  localparam logic [7:0] RA [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24,
    8'h28, 8'h40};
  localparam logic [31:0] RV [12] = '{32'h3, 32'h7d0, 32'h7d0, 32'h7d0, 32'h7d0, 32'h50, 32'h64, 32'h5dc,
    32'hfa, 32'h2710, 32'h9c40, 32'h7fff};

  // Short millisecond keeps the delays at 400 and 1000 cycles.
  slm_top #(.MS_CYCLES(4)) slm_top_i (.mclk, .rst_n, .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .select_req(sel), .select_via_fieldbus(fbus), .level_req(lvl), .elec_speed(ev), .slip_speed(slip),
    .setpoint_in(sp_in), .setpoint_out(sp_out), .quick_stop_req(qs), .quick_stop_ramp_time(qst),
    .ramp_pos_speed_limit(lpos), .ramp_neg_speed_limit(lneg), .limited_speed_active_flag(act),
    .stop_a_req(sa), .stop_b_req(sb), .irq);
  slm_drive_model slm_drive_model_i (.mclk, .rst_n, .setpoint_out(sp_out), .elec_speed(mdl_ev));
  // The bench overrides the speed to provoke an excess the model would never reach.
  assign ev = force_on ? frc_ev : mdl_ev;

  // Clock of 25 ns.
  always #12.5 mclk = ~mclk;

  task automatic conclude;
    if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Bounded wait for a level, sampled where it is settled.
  task automatic wait_hi(ref logic s);
    nw = 0;
    @(negedge mclk);
    while (s !== 1'b1) begin
      if (nw > 5000) begin
        `CHK("wait", 1'b1, 1'b0)
        conclude();
      end
      @(negedge mclk);
      nw++;
    end
  endtask : wait_hi

  // Bus cycles; ready is offered with the request, so answers are taken at once.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    wait_hi(awr);
    @(posedge mclk);
    awv <= 1'b0;
    wv <= 1'b0;
    wait_hi(bv);
    @(posedge mclk);
    bry <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a);
    @(posedge mclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    wait_hi(arr);
    @(posedge mclk);
    arv <= 1'b0;
    wait_hi(rv);
    rdat = rd_d;
    rrsp = rr;
    @(posedge mclk);
    rry <= 1'b0;
  endtask : axr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    `CHK($sformatf("reg %h", a), e, rdat)
  endtask : rchk

  task automatic t_reset;
    for (int i = 0; i < 12; i++) rchk(RA[i], RV[i]);
    `CHK("ramp time", 16'h03e8, qst)
    axr(8'h58);
    `CHK("unmapped", 2'h3, rrsp)
    axw(8'h58, 32'h0);
    `CHK("unmapped wr", 2'h3, br)
    axw(8'h28, 32'h30d40);
    rchk(8'h28, 32'h186a0);
  endtask : t_reset

  task automatic t_delay;
    axw(8'h04, 32'h3e8);
    axw(8'h54, 32'h1);
    axw(8'h00, 32'h7);
    sp_in <= 16'h0258;
    lvl <= 2'h3;
    sel <= 1'b1;
    wait_hi(qs);
    repeat (3) @(negedge mclk);
    `CHK("pos limit", 16'h0320, lpos)
    `CHK("neg limit", 16'hfce0, lneg)
    wait_hi(act);
    `CHK("delay", 1'b1, nw > 380)
    rchk(8'h3c, 32'h3e8);
    rchk(8'h48, 32'h320);
    rchk(8'h30, 32'h1);
    axw(8'h28, 32'h5);
    axw(8'h00, 32'h17);
    @(negedge mclk);
    `CHK("accept limit", 16'h7fff, lpos)
    repeat (30) @(negedge mclk);
    `CHK("restored", 16'h0320, lpos)
    @(posedge mclk);
    frc_ev <= 16'h04b0;
    force_on <= 1'b1;
    wait_hi(sa);
    `CHK("stop b", 1'b0, sb)
    `CHK("irq set", 1'b1, irq)
    axw(8'h50, 32'h1);
    sel <= 1'b0;
    force_on <= 1'b0;
    repeat (4) @(negedge mclk);
    `CHK("irq clear", 1'b0, irq)
    `CHK("stop release", 1'b0, sa)
  endtask : t_delay

  task automatic t_fbus;
    axw(8'h0c, 32'h104b0);
    axw(8'h00, 32'hf);
    slip <= 16'h0190;
    frc_ev <= 16'h0514;
    force_on <= 1'b1;
    fbus <= 1'b1;
    lvl <= 2'h2;
    sel <= 1'b1;
    wait_hi(act);
    rchk(8'h34, 32'h384);
    rchk(8'h40, 32'h3c0);
    slip <= 16'h0000;
    wait_hi(sb);
    `CHK("stop a", 1'b0, sa)
    @(posedge mclk);
    sel <= 1'b0;
    fbus <= 1'b0;
    force_on <= 1'b0;
  endtask : t_fbus

  task automatic t_off;
    axw(8'h00, 32'h6);
    sel <= 1'b1;
    repeat (20) @(negedge mclk);
    `CHK("brake off", 1'b0, qs)
    `CHK("limit off", 16'h7fff, lpos)
    @(posedge mclk);
    sel <= 1'b0;
  endtask : t_off

  task automatic t_ramp;
    axw(8'h24, 32'h64);
    axw(8'h00, 32'h3);
    sp_in <= 16'h0708;
    repeat (300) @(posedge mclk);
    sel <= 1'b1;
    rchk(8'h38, 32'h708);
    wait_hi(act);
    `CHK("ramp delay", 1'b1, nw > 1000)
    `CHK("setpoint", 16'h0320, sp_out)
  endtask : t_ramp

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    mclk = 1'b0;
    {rst_n, sel, fbus, force_on, awv, wv, bry, arv, rry} = '0;
    {lvl, slip, sp_in, frc_ev, awa, ara, wd} = '0;
    ws = 4'hf;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_delay();
    t_fbus();
    t_off();
    t_ramp();
    conclude();
  end
endmodule : slm_top_bench
